/* File: logic/pcp_pkg.sv */
// Purpose: Shared constants and types of the parallel configuration port.
// Assumes: Single core_clk at 25 MHz; all pins arrive asynchronous.
// Notes: Function list below; tags mark the logic that carries each one.
// Function
// - Configuration mode is chosen from the two mode-select pins before loading.
// - Config clock paces every mode; device drives it as master, host as slave.
// - Writes and readback on the 16-bit data bus follow config clock rising edges.
// - Completion flag is 0 while unconfigured and 1 once configured.
// - After mode sampling init line is open-drain error output, low on CRC error.
// - With upset detection on, init line never returns to user I/O.
// - Program pin low resets the whole device; source must meet minimum width.
// - Parallel data bus enabled only while active-low chip select is 0.
// - Read/write select 0 makes data pins inputs, 1 makes them outputs.
// - Read/write select changes only while deselected; otherwise an abort. The code detects the abort only in load and startup.
// - Active-low downstream select output enables the next chained device.
// - Busy output gives readback flow control and may toggle while loading.
// - Master data bus is 8 or 16 bits wide, matched by the PROM.
// - Completion pin is open-drain by default, actively driven by option.
// - Startup sequence is clocked by the config clock.
// - While deselected no inputs are taken, no outputs driven, select ignored.
// - Write direction samples pins each rising edge; read direction updates them.
// - Abort shows on busy at once; status updates at next rising edge.
// - Startup lasts at least eight config clocks; controller keeps clocking.
package pcp_pkg;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 26;
  localparam int MODE_W = 2;

  // Mode-select encodings
  localparam logic [MODE_W-1:0] MODE_MASTER_PAR = 2'h0;
  localparam logic [MODE_W-1:0] MODE_SLAVE_PAR = 2'h1;

  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int CONFIG_CLOCK_HALF_NS = 200;
  localparam int CONFIG_CLOCK_HALF_CYC = (CONFIG_CLOCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLEAR_CYC = 4;
  localparam int STARTUP_CYC = 8;
  localparam int CNT_W = 4;

  localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 26'h0000000;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 26'h0000001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

  typedef enum logic [2:0] {
    ST_CLEAR = 3'b000,
    ST_INIT_WAIT = 3'b001,
    ST_LOAD = 3'b010,
    ST_STARTUP = 3'b011,
    ST_DONE = 3'b100,
    ST_IDLE = 3'b101
  } pcp_state_t;

  typedef struct packed {
    logic wide;
    logic [DATA_W-1:0] data;
  } pcp_word_t;

  typedef struct packed {
    logic done;
    logic crc_error;
    logic abort;
    logic mode_valid;
    logic [MODE_W-1:0] mode;
  } pcp_status_t;

endpackage : pcp_pkg

/* File: logic/pcp_fifo.sv */
// Purpose: Small valid/ready FIFO in the configuration data path.
// Assumes: DEPTH is a power of two.
// Notes: Full and empty are exact; simultaneous push and pop allowed.
`timescale 1ns/1ps
`default_nettype none
module pcp_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic clear,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0] wr_ptr_ff;
  logic [AW:0] rd_ptr_ff;
  wire full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  wire empty = (wr_ptr_ff == rd_ptr_ff);
  wire push = in_valid && !full;
  wire pop = out_valid && out_ready;

  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_ff[rd_ptr_ff[AW-1:0]];

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (clear) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
    end
  end

endmodule : pcp_fifo
`default_nettype wire

/* File: logic/pcp_port.sv */
// Purpose: Parallel byte/halfword configuration port of the device.
// Assumes: All pins asynchronous to core_clk; slave clock well below core_clk/4.
// Notes: Program pin acts through a synchroniser, so reset lags it by two cycles.
`timescale 1ns/1ps
`default_nettype none
module pcp_port
  import pcp_pkg::*;
#(
  parameter int FIFO_DEPTH = 4,
  parameter int HALF_CYC = CONFIG_CLOCK_HALF_CYC,
  parameter int STARTUP_CYCLES = STARTUP_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Full-chip reset and mode pins
  input wire logic program_n,
  input wire logic [MODE_W-1:0] mode_sel,
  // Configuration clock pin
  input wire logic config_clock_in,
  output logic config_clock_out,
  output logic config_clock_oe,
  // Data bus pins
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic chip_select_n,
  input wire logic read_write_select,
  // Status pins
  input wire logic init_in,
  output logic init_out,
  output logic init_oe,
  output logic completion_out,
  output logic completion_oe,
  output logic downstream_select_n,
  output logic busy,
  // Flash pins
  output logic [ADDR_W-1:0] flash_addr,
  output logic flash_output_enable_n,
  output logic flash_chip_enable_n,
  output logic flash_write_enable_n,
  // Options
  input wire logic bus_width_16,
  input wire logic completion_active_drive,
  input wire logic seu_detect_enable,
  // Configuration core side
  output pcp_word_t cfg_word,
  output logic cfg_valid,
  input wire logic cfg_ready,
  input wire logic crc_error,
  input wire logic startup_cmd,
  input wire logic [DATA_W-1:0] rb_data,
  input wire logic rb_valid,
  output logic rb_ready,
  // Status
  output pcp_status_t status,
  output logic init_user_release
);

  // Two-flop synchronisers on every pin input
  logic prog_s1_ff, prog_s2_ff;
  logic config_clock_s1_ff, config_clock_s2_ff, config_clock_prev_ff;
  logic cs_s1_ff, cs_s2_ff, cs_prev_ff;
  logic rw_s1_ff, rw_s2_ff, rw_prev_ff;
  logic init_s1_ff, init_s2_ff;
  logic [MODE_W-1:0] mode_s1_ff, mode_s2_ff;
  logic [DATA_W-1:0] data_s1_ff, data_s2_ff;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      prog_s1_ff <= 1'b0;
      prog_s2_ff <= 1'b0;
    end else begin
      prog_s1_ff <= program_n;
      prog_s2_ff <= prog_s1_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    config_clock_s1_ff <= config_clock_in;
    config_clock_s2_ff <= config_clock_s1_ff;
    cs_s1_ff <= chip_select_n;
    cs_s2_ff <= cs_s1_ff;
    rw_s1_ff <= read_write_select;
    rw_s2_ff <= rw_s1_ff;
    init_s1_ff <= init_in;
    init_s2_ff <= init_s1_ff;
    mode_s1_ff <= mode_sel;
    mode_s2_ff <= mode_s1_ff;
    data_s1_ff <= data_in;
    data_s2_ff <= data_s1_ff;
  end

  // Full-chip clear from either reset source
  wire clear = !resetn || !prog_s2_ff;

  pcp_state_t state_ff, nxt_state;
  logic [MODE_W-1:0] mode_ff;
  logic mode_valid_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] div_ff;
  logic config_clock_lvl_ff;
  logic crc_err_ff;
  logic abort_seen_ff;
  logic abort_stat_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] dout_ff;

  // Decode
  wire is_master = mode_valid_ff && (mode_ff == MODE_MASTER_PAR);
  wire is_slave = mode_valid_ff && (mode_ff == MODE_SLAVE_PAR);
  wire selected = !cs_s2_ff;
  wire writing = selected && !rw_s2_ff;
  wire reading = selected && rw_s2_ff;
  wire busy_state = (state_ff == ST_LOAD) || (state_ff == ST_STARTUP);
  wire config_clock_run = busy_state || (state_ff == ST_DONE);
  wire fifo_ready;
  wire fifo_out_valid;
  wire slave_rise = is_slave && config_clock_s2_ff && !config_clock_prev_ff;
  wire master_tick = is_master && config_clock_run && (div_ff == CNT_ZERO);
  wire master_hold = !config_clock_lvl_ff && !fifo_ready && (state_ff == ST_LOAD);
  wire master_rise = master_tick && !config_clock_lvl_ff && !master_hold;
  wire config_clock_rise = slave_rise || master_rise;
  // Rule change of direction while selected during loading or startup
  wire abort_now = busy_state && selected && !cs_prev_ff && (rw_s2_ff != rw_prev_ff);
  wire take_word = config_clock_rise && writing && (state_ff == ST_LOAD) && !abort_seen_ff;
  wire rb_allowed = (state_ff == ST_DONE);
  wire rb_take = config_clock_rise && reading && rb_allowed && rb_valid;
  localparam logic [CNT_W-1:0] CNT_CALC_END = CNT_W'(STARTUP_CYCLES - 1);
  localparam logic [CNT_W-1:0] CLEAR_END = CNT_W'(CLEAR_CYC - 1);
  localparam logic [CNT_W-1:0] HALF_END = CNT_W'(HALF_CYC - 1);
  wire startup_end = (state_ff == ST_STARTUP) && config_clock_rise &&
    (cnt_ff == CNT_CALC_END);

  pcp_word_t in_word;
  assign in_word.wide = bus_width_16;
  assign in_word.data = bus_width_16 ? data_s2_ff : {8'h00, data_s2_ff[7:0]};

  pcp_fifo #(
    .WIDTH($bits(pcp_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .clear(clear),
    .in_valid(take_word),
    .in_ready(fifo_ready),
    .in_data(in_word),
    .out_valid(fifo_out_valid),
    .out_ready(cfg_ready),
    .out_data(cfg_word)
  );
  assign cfg_valid = fifo_out_valid;

  // Sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_CLEAR: begin
        if (cnt_ff == CLEAR_END) begin
          nxt_state = ST_INIT_WAIT;
        end
      end
      ST_INIT_WAIT: begin
        if (init_s2_ff) begin
          if ((mode_s2_ff == MODE_MASTER_PAR) || (mode_s2_ff == MODE_SLAVE_PAR)) begin
            nxt_state = ST_LOAD;
          end else begin
            nxt_state = ST_IDLE;
          end
        end
      end
      ST_LOAD: begin
        if (startup_cmd) begin
          nxt_state = ST_STARTUP;
        end
      end
      ST_STARTUP: begin
        if (startup_end) begin
          nxt_state = ST_DONE;
        end
      end
      ST_DONE: nxt_state = ST_DONE;
      ST_IDLE: nxt_state = ST_IDLE;
      default: nxt_state = ST_CLEAR;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (clear) begin
      state_ff <= ST_CLEAR;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Clear and startup counter
  always_ff @(posedge core_clk) begin
    if (clear || (state_ff != nxt_state)) begin
      cnt_ff <= CNT_ZERO;
    end else if (state_ff == ST_CLEAR) begin
      cnt_ff <= cnt_ff + CNT_ONE;
    end else if ((state_ff == ST_STARTUP) && config_clock_rise) begin
      cnt_ff <= cnt_ff + CNT_ONE;
    end
  end

  // Mode capture, once per attempt
  always_ff @(posedge core_clk) begin
    if (clear) begin
      mode_ff <= MODE_MASTER_PAR;
      mode_valid_ff <= 1'b0;
    end else if ((state_ff == ST_INIT_WAIT) && init_s2_ff) begin
      mode_ff <= mode_s2_ff;
      mode_valid_ff <= 1'b1;
    end
  end

  // Master clock divider, quiet until mode is known
  always_ff @(posedge core_clk) begin
    if (clear || !is_master || !config_clock_run) begin
      div_ff <= HALF_END;
      config_clock_lvl_ff <= 1'b0;
    end else if (div_ff == CNT_ZERO) begin
      div_ff <= HALF_END;
      if (!master_hold) begin
        config_clock_lvl_ff <= !config_clock_lvl_ff;
      end
    end else begin
      div_ff <= div_ff - CNT_ONE;
    end
  end

  // Edge and direction history
  always_ff @(posedge core_clk) begin
    if (clear) begin
      config_clock_prev_ff <= 1'b0;
      cs_prev_ff <= 1'b1;
      rw_prev_ff <= 1'b0;
    end else begin
      config_clock_prev_ff <= config_clock_s2_ff;
      cs_prev_ff <= cs_s2_ff;
      rw_prev_ff <= rw_s2_ff;
    end
  end

  // Abort: busy at once, status at next rising edge
  always_ff @(posedge core_clk) begin
    if (clear) begin
      abort_seen_ff <= 1'b0;
      abort_stat_ff <= 1'b0;
    end else begin
      if (abort_now) begin
        abort_seen_ff <= 1'b1;
      end else if (!selected) begin
        abort_seen_ff <= 1'b0;
      end
      if (config_clock_rise && (abort_seen_ff || abort_now)) begin
        abort_stat_ff <= 1'b1;
      end else if (!selected) begin
        abort_stat_ff <= 1'b0;
      end
    end
  end

  // Sticky CRC error until full reset
  always_ff @(posedge core_clk) begin
    if (clear) begin
      crc_err_ff <= 1'b0;
    end else if (crc_error && mode_valid_ff) begin
      crc_err_ff <= 1'b1;
    end
  end

  // Flash address walks with each master word
  always_ff @(posedge core_clk) begin
    if (clear) begin
      addr_ff <= ADDR_ZERO;
    end else if (take_word && is_master) begin
      addr_ff <= addr_ff + ADDR_ONE;
    end
  end

  // Readback data updated on rising edges
  always_ff @(posedge core_clk) begin
    if (clear) begin
      dout_ff <= DATA_ZERO;
    end else if (rb_take) begin
      dout_ff <= rb_data;
    end
  end

  wire done_w = (state_ff == ST_DONE);
  assign rb_ready = rb_take;
  assign data_out = dout_ff;
  assign data_oe = reading && !clear;
  assign config_clock_out = config_clock_lvl_ff;
  assign config_clock_oe = is_master && !clear;
  assign init_out = 1'b0;
  assign init_oe = (state_ff == ST_CLEAR) || clear || crc_err_ff;
  assign init_user_release = done_w && !seu_detect_enable && !crc_err_ff;
  assign completion_out = completion_active_drive ? done_w : 1'b0;
  // Active driver keeps the pin low through a full-chip clear as well
  assign completion_oe = completion_active_drive ? 1'b1 : !done_w;
  assign downstream_select_n = !(done_w && selected);
  // Flow control: abort, full buffer, or readback not ready
  assign busy = abort_now || abort_seen_ff ||
    (writing && (state_ff == ST_LOAD) && !fifo_ready) ||
    (reading && !(rb_allowed && rb_valid));
  assign flash_addr = addr_ff;
  assign flash_output_enable_n = !(is_master && (state_ff == ST_LOAD));
  assign flash_chip_enable_n = !(is_master && (state_ff == ST_LOAD));
  assign flash_write_enable_n = 1'b1;
  assign status.done = done_w;
  assign status.crc_error = crc_err_ff;
  assign status.abort = abort_stat_ff;
  assign status.mode_valid = mode_valid_ff;
  assign status.mode = mode_ff;

endmodule : pcp_port
`default_nettype wire

/* File: tb/pcp_assertions.sv */
// Purpose: Port-level checker for pcp_port.
// Assumes: Bound to every pcp_port instance.
// Notes: Single clock domain; disabled while resetn is low.
`timescale 1ns/1ps
`default_nettype none
module pcp_assertions
  import pcp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Parallel port pins
  input wire logic chip_select_n,
  input wire logic read_write_select,
  input wire logic data_oe,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic busy,
  input wire logic config_clock_oe,
  input wire logic downstream_select_n,
  // Status pins and options
  input wire logic init_oe,
  input wire logic init_user_release,
  input wire logic seu_detect_enable,
  input wire logic completion_out,
  input wire logic completion_oe,
  input wire logic completion_active_drive,
  // Core side
  input wire logic [DATA_W-1:0] rb_data,
  input wire logic rb_ready,
  input wire pcp_status_t status
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  AST_DESEL: assert property (chip_select_n [*4] |-> !data_oe)
    else $error("bus driven while deselected");
  AST_WRITE_DIR: assert property (!read_write_select [*4] |-> !data_oe)
    else $error("bus driven in write direction");
  AST_UNCONF: assert property (!status.done |-> completion_oe && !completion_out)
    else $error("completion not held low");
  AST_DRIVE: assert property (status.done && completion_active_drive
    && $past(completion_active_drive, 3) |-> completion_oe && completion_out)
    else $error("completion not driven high");
  AST_CRC: assert property (status.crc_error |-> init_oe)
    else $error("init not pulled on crc error");
  AST_SEU: assert property (seu_detect_enable [*3] |-> !init_user_release)
    else $error("init released with upset detection");
  AST_ABORT: assert property ($rose(status.abort) |-> busy)
    else $error("abort flag without busy");
  AST_CLK_OE: assert property (config_clock_oe
    |-> status.mode_valid && status.mode == MODE_MASTER_PAR)
    else $error("clock driven outside master mode");
  AST_CHAIN: assert property (!downstream_select_n |-> status.done)
    else $error("chain select before done");
  AST_READBACK: assert property (rb_ready |=> data_out == $past(rb_data))
    else $error("readback word not on bus");
endmodule : pcp_assertions

bind pcp_port pcp_assertions chk_i (.core_clk, .resetn, .chip_select_n, .read_write_select,
  .data_oe, .data_out, .busy, .config_clock_oe, .downstream_select_n, .init_oe,
  .init_user_release, .seu_detect_enable, .completion_out, .completion_oe,
  .completion_active_drive, .rb_data, .rb_ready, .status);
`default_nettype wire

/* File: tb/pcp_host_model.sv */
// Purpose: Host controller on the parallel port pins.
// Assumes: Tasks are called from the bench.
// Notes: Clock idles low between transfers.
`timescale 1ns/1ps
`default_nettype none
module pcp_host_model
  import pcp_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Host-driven pins
  output logic config_clock_in,
  output logic [DATA_W-1:0] data_in,
  output logic chip_select_n,
  output logic read_write_select,
  // Device-driven pins
  input wire logic data_oe
);
  initial begin
    config_clock_in = 1'b0;
    data_in = DATA_ZERO;
    chip_select_n = 1'b1;
    read_write_select = 1'b0;
  end
  // Released bus shows a changing pattern
  always @(posedge core_clk) begin
    if (data_oe) begin
      data_in <= ~data_in;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic pulse();
    tick(4);
    config_clock_in = 1'b1;
    tick(4);
    config_clock_in = 1'b0;
  endtask : pulse
  // Data held across the rise, then scrambled
  task automatic send(input logic [DATA_W-1:0] w);
    data_in = w;
    pulse();
    data_in = ~w;
  endtask : send
  task automatic sel(input logic cs_n, input logic rw);
    chip_select_n = 1'b1;
    tick(4);
    read_write_select = rw;
    tick(4);
    chip_select_n = cs_n;
    tick(4);
  endtask : sel
  // Deliberate change while selected
  task automatic flip();
    read_write_select = ~read_write_select;
    tick(4);
  endtask : flip
endmodule : pcp_host_model
`default_nettype wire

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench for pcp_port.
// Assumes: Host model drives the pins; bench drives the core side.
// Notes: Slave run first, then a master run.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import pcp_pkg::*;
;
  logic core_clk, resetn, program_n, config_clock_in, config_clock_out, config_clock_oe;
  logic [MODE_W-1:0] mode_sel;
  logic [DATA_W-1:0] data_in, data_out, rb_data;
  logic data_oe, chip_select_n, read_write_select, init_in, init_out, init_oe, init_hold;
  logic completion_out, completion_oe, downstream_select_n, busy, init_user_release;
  logic [ADDR_W-1:0] flash_addr, a1;
  logic flash_output_enable_n, flash_chip_enable_n, flash_write_enable_n;
  logic bus_width_16, completion_active_drive, seu_detect_enable;
  logic cfg_valid, cfg_ready, crc_error, startup_cmd, rb_valid, rb_ready;
  pcp_word_t cfg_word;
  pcp_status_t status;
  int err_total;
  int n_compared;

  assign init_in = !(init_oe || init_hold);
  pcp_port dut (.core_clk, .resetn, .program_n, .mode_sel, .config_clock_in, .config_clock_out,
    .config_clock_oe, .data_in, .data_out, .data_oe, .chip_select_n, .read_write_select,
    .init_in, .init_out, .init_oe, .completion_out, .completion_oe, .downstream_select_n,
    .busy, .flash_addr, .flash_output_enable_n, .flash_chip_enable_n, .flash_write_enable_n,
    .bus_width_16, .completion_active_drive, .seu_detect_enable, .cfg_word, .cfg_valid,
    .cfg_ready, .crc_error, .startup_cmd, .rb_data, .rb_valid, .rb_ready, .status,
    .init_user_release);
  pcp_host_model host (.core_clk, .config_clock_in, .data_in, .chip_select_n,
    .read_write_select, .data_oe);

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic chk(input string nm, input logic [ADDR_W-1:0] seen,
    input logic [ADDR_W-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wrap_up();
    if (err_total == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  task automatic t_reset(input logic [MODE_W-1:0] m);
    resetn = 1'b0;
    mode_sel = m;
    init_hold = 1'b1;
    tick(12);
    chk("rst_oe", {completion_oe, init_oe, data_oe}, 3'b110);
    resetn = 1'b1;
    tick(30);
    chk("mode_wait", status.mode_valid, 1'b0);
    init_hold = 1'b0;
    tick(10);
    chk("mode", {status.mode_valid, status.mode}, {1'b1, m});
    mode_sel = ~m;
    tick(10);
    chk("mode_hold", status.mode, m);
  endtask : t_reset
  task automatic pop(input logic [16:0] exp);
    int i;
    i = 0;
    while (cfg_valid !== 1'b1 && i < 50) begin
      tick(1);
      i++;
    end
    chk("word", cfg_word, exp);
    cfg_ready = 1'b1;
    tick(1);
    cfg_ready = 1'b0;
  endtask : pop
  task automatic t_load();
    host.sel(1'b0, 1'b0);
    host.send(16'hA55A);
    host.send(16'h0F0F);
    bus_width_16 = 1'b0;
    host.send(16'h12C3);
    host.send(16'hFF81);
    tick(4);
    chk("full_busy", busy, 1'b1);
    host.send(16'h7777);
    pop({1'b1, 16'hA55A});
    pop({1'b1, 16'h0F0F});
    pop({1'b0, 16'h00C3});
    pop({1'b0, 16'h0081});
    tick(2);
    chk("lost", cfg_valid, 1'b0);
  endtask : t_load
  task automatic t_abort();
    host.flip();
    chk("abort_busy", busy, 1'b1);
    host.pulse();
    chk("abort_flag", status.abort, 1'b1);
    host.sel(1'b1, 1'b0);
    chk("abort_clr", {busy, status.abort}, 2'b00);
    host.sel(1'b0, 1'b0);
  endtask : t_abort
  task automatic t_start();
    startup_cmd = 1'b1;
    tick(1);
    startup_cmd = 1'b0;
    repeat (7) host.pulse();
    chk("early", {status.done, completion_oe}, 2'b01);
    host.pulse();
    chk("done", {status.done, completion_oe, completion_out}, 3'b100);
    chk("chain", downstream_select_n, 1'b0);
    chk("user_io", init_user_release, 1'b1);
    completion_active_drive = 1'b1;
    seu_detect_enable = 1'b1;
    tick(4);
    chk("drive", {completion_oe, completion_out, init_user_release}, 3'b110);
  endtask : t_start
  task automatic t_read();
    rb_data = 16'hBEEF;
    rb_valid = 1'b1;
    host.sel(1'b0, 1'b1);
    chk("rd_oe", data_oe, 1'b1);
    host.pulse();
    rb_valid = 1'b0;
    chk("rd_data", data_out, 16'hBEEF);
    host.sel(1'b1, 1'b1);
    chk("desel_oe", data_oe, 1'b0);
    program_n = 1'b0;
    tick(4);
    chk("prog", {status.done, init_oe}, 2'b01);
    program_n = 1'b1;
  endtask : t_read
  task automatic t_master();
    t_reset(MODE_MASTER_PAR);
    host.sel(1'b0, 1'b0);
    cfg_ready = 1'b1;
    tick(20);
    a1 = flash_addr;
    tick(20);
    chk("addr", flash_addr, a1 + 26'h0000002);
    chk("pins", {config_clock_oe, flash_output_enable_n, flash_write_enable_n}, 3'b101);
    chk("flash_ce", flash_chip_enable_n, 1'b0);
    cfg_ready = 1'b0;
    tick(100);
    a1 = flash_addr;
    tick(40);
    chk("stall", flash_addr, a1);
    chk("stall_clk", config_clock_out, 1'b0);
    crc_error = 1'b1;
    tick(1);
    crc_error = 1'b0;
    tick(3);
    chk("crc", {init_oe, init_out, status.crc_error}, 3'b101);
  endtask : t_master

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    #(CLK_PERIOD_NS * 10000);
    err_total++;
    wrap_up();
  end
  initial begin
    err_total = 0;
    n_compared = 0;
    resetn = 1'b0;
    program_n = 1'b1;
    mode_sel = MODE_SLAVE_PAR;
    init_hold = 1'b1;
    bus_width_16 = 1'b1;
    completion_active_drive = 1'b0;
    seu_detect_enable = 1'b0;
    cfg_ready = 1'b0;
    crc_error = 1'b0;
    startup_cmd = 1'b0;
    rb_data = DATA_ZERO;
    rb_valid = 1'b0;
    t_reset(MODE_SLAVE_PAR);
    t_load();
    t_abort();
    t_start();
    t_read();
    t_master();
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
